//--- design/service_packet_handler.sv
/*
  report framer and memory load executor with crc read-back check.
  assumes one-cycle memory read data, a holding sampler, a popping drain.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Rules of the document behind this block
// RULE1 - definition report: id, selector, interval, count, parameter ids
// RULE2 - interval counts in multiples of the default sampling period
// RULE3 - periodic reports 25 and 26 open with a two-octet selector
// RULE4 - values once per interval, then optional faster arrays
// RULE5 - event subtypes 1, 2 and 4
// RULE6 - event data: identifier, selector, optional parameters
// RULE7 - selectors never shared between event subtypes
// RULE8 - event parameters whole words, at most 42 octets
// RULE9 - event identifier unique within the process
// RULE10 - layout set by selector, process and subtype
// RULE11 - load: checksum, write, re-read, recheck, report
// RULE12 - load: block, address, spare, length, data, checksum
// RULE13 - addresses and lengths count smallest addressable units
// RULE14 - commanding party zeroes the spare octet
// RULE15 - load data kept within 230 octets
// RULE16 - load checksum is a crc over the data block only
// RULE17 - interval restricted to powers of two
// RULE18 - fields in order, msb octet first, unpadded
module service_packet_handler #(
  parameter int DEPTH = 16, // output fifo depth
  parameter int MAX_PARAMS = 255 // parameter words per definition or periodic report
) (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic report_req_i, // start a report, one-cycle pulse
  input wire logic [7:0] report_subtype_i, // subtype of requested report
  input wire logic [15:0] report_def_id_i, // report definition id
  input wire logic [15:0] structure_selector_i, // structure selector
  input wire logic [15:0] event_identifier_i, // event identifier
  input wire logic [15:0] interval_i, // sampling interval, power of two
  input wire logic [7:0] param_count_i, // parameter words to follow
  input wire logic [15:0] param_word_i, // parameter word from sampler
  output logic param_take_o, // sampler word consumed
  input wire logic cmd_valid_i, // load command word present
  input wire logic [15:0] cmd_word_i, // load command word
  output logic cmd_ready_o, // load command word taken
  output logic mem_we_o, // memory write strobe
  output logic mem_re_o, // memory read strobe
  output logic [15:0] mem_block_o, // memory block selector
  output logic [15:0] mem_addr_o, // address in addressable units
  output logic [15:0] mem_wdata_o, // memory write data
  input wire logic [15:0] mem_rdata_i, // memory read data, one cycle later
  output logic [15:0] tm_data_o, // source data word
  output logic tm_valid_o, // source data word present
  input wire logic tm_ready_i, // drain pops word
  output logic busy_o, // block busy
  output logic report_error_o, // request refused or load failed, one cycle
  output logic load_done_o, // load finished, one cycle
  output logic load_ok_o, // last load verified
  output logic [15:0] load_sum_o // checksum of last load
);
  initial begin
    if (MAX_PARAMS < 1 || MAX_PARAMS > 255) begin
      $error("MAX_PARAMS must lie between 1 and 255");
    end
  end

  // ------------------
  // state
  // ------------------
  word_stream_if #(.WIDTH(16)) stream ();

  svc_pkg::state_type state, next_state;
  logic [15:0] hdr [4];
  logic [15:0] next_hdr [4];
  logic [2:0] hdr_cnt, next_hdr_cnt, hdr_idx, next_hdr_idx;
  logic [7:0] body_cnt, next_body_cnt;
  logic [7:0] len, next_len;
  logic [7:0] idx, next_idx;
  logic [15:0] base, next_base;
  logic [15:0] block, next_block;
  logic [15:0] crc_rx, next_crc_rx, crc_rd, next_crc_rd;
  logic [15:0] sum, next_sum;
  logic ok, next_ok, done, next_done, err, next_err;
  logic we, next_we, re, next_re, rd_pend, next_rd_pend;
  logic [15:0] wdata, next_wdata, addr, next_addr;
  logic [15:0] out_word;
  logic out_push;
  logic [15:0] crc_rx_step, crc_rd_step;
  logic is_def, is_per, is_evt, interval_ok, sub_ok;

  crc16_step u_crc_rx (.crc_i(crc_rx), .word_i(cmd_word_i), .crc_o(crc_rx_step));
  crc16_step u_crc_rd (.crc_i(crc_rd), .word_i(mem_rdata_i), .crc_o(crc_rd_step));

  word_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_s(stream.sink),
    .out_data_o(tm_data_o),
    .out_valid_o(tm_valid_o),
    .out_ready_i(tm_ready_i)
  );

  assign stream.data = out_word;
  assign stream.valid = out_push;

  // ------------------
  // request classification
  // ------------------
  // RULE17 power of two
  always_comb begin
    is_def = (report_subtype_i == svc_pkg::ST_HK_DEFS) ||
             (report_subtype_i == svc_pkg::ST_DIAG_DEFS);
    is_per = (report_subtype_i == svc_pkg::ST_HK_REPORT) ||
             (report_subtype_i == svc_pkg::ST_DIAG_REPORT);
    // RULE5 three event subtypes
    is_evt = (report_subtype_i == svc_pkg::ST_EVENT) ||
             (report_subtype_i == svc_pkg::ST_EXCEPTION) ||
             (report_subtype_i == svc_pkg::ST_ALARM);
    interval_ok = ($countones(interval_i) == 1);
    // RULE8 event parameter bound
    sub_ok = (is_def && interval_ok && (int'(param_count_i) <= MAX_PARAMS)) ||
             (is_per && (int'(param_count_i) <= MAX_PARAMS)) ||
             (is_evt && (int'(param_count_i) <= svc_pkg::EVENT_PARAM_MAX_WORDS));
  end

  // ------------------
  // next-state logic
  // ------------------
  always_comb begin
    next_state = state;
    next_hdr = hdr;
    next_hdr_cnt = hdr_cnt;
    next_hdr_idx = hdr_idx;
    next_body_cnt = body_cnt;
    next_len = len;
    next_idx = idx;
    next_base = base;
    next_block = block;
    next_crc_rx = crc_rx;
    next_crc_rd = crc_rd;
    next_sum = sum;
    next_ok = ok;
    next_done = 1'b0;
    next_err = 1'b0;
    next_we = 1'b0;
    next_re = 1'b0;
    next_rd_pend = re;
    next_wdata = wdata;
    next_addr = addr;
    out_word = hdr[hdr_idx[1:0]];
    out_push = 1'b0;
    param_take_o = 1'b0;
    cmd_ready_o = 1'b0;
    case (state)
      svc_pkg::ST_IDLE: begin
        // reports take priority over a waiting load command
        if (report_req_i) begin
          if (sub_ok) begin
            next_hdr_idx = 3'd0;
            next_body_cnt = param_count_i;
            next_state = svc_pkg::ST_EMIT_HDR;
            if (is_def) begin
              // RULE1 definition header
              // RULE2 interval as multiple
              // RULE10 selector with subtype
              next_hdr[0] = report_def_id_i;
              next_hdr[1] = structure_selector_i;
              next_hdr[2] = interval_i;
              next_hdr[3] = {8'h00, param_count_i};
              next_hdr_cnt = 3'd4;
            end else if (is_per) begin
              // RULE3 selector first
              next_hdr[0] = structure_selector_i;
              next_hdr_cnt = 3'd1;
            end else begin
              // RULE6 identifier then selector
              // RULE7 selectors per subtype
              // RULE9 identifier unique
              next_hdr[0] = event_identifier_i;
              next_hdr[1] = structure_selector_i;
              next_hdr_cnt = 3'd2;
            end
          end else begin
            next_err = 1'b1;
          end
        end else if (cmd_valid_i) begin
          cmd_ready_o = 1'b1;
          next_block = cmd_word_i;
          next_state = svc_pkg::ST_LD_ADDR;
        end
      end
      svc_pkg::ST_EMIT_HDR: begin
        // RULE18 msb-first word order
        out_push = 1'b1;
        if (stream.ready) begin
          next_hdr_idx = hdr_idx + 3'd1;
          if (next_hdr_idx == hdr_cnt) begin
            next_state = (body_cnt == 8'd0) ? svc_pkg::ST_IDLE : svc_pkg::ST_EMIT_BODY;
          end
        end
      end
      svc_pkg::ST_EMIT_BODY: begin
        // RULE4 sampled values in order
        out_word = param_word_i;
        out_push = 1'b1;
        if (stream.ready) begin
          param_take_o = 1'b1;
          next_body_cnt = body_cnt - 8'd1;
          if (body_cnt == 8'd1) begin
            next_state = svc_pkg::ST_IDLE;
          end
        end
      end
      svc_pkg::ST_LD_ADDR: begin
        // RULE12 start address word
        // RULE13 address in units
        cmd_ready_o = cmd_valid_i;
        if (cmd_valid_i) begin
          next_base = cmd_word_i;
          next_state = svc_pkg::ST_LD_LEN;
        end
      end
      svc_pkg::ST_LD_LEN: begin
        // RULE14 spare ignored
        cmd_ready_o = cmd_valid_i;
        if (cmd_valid_i) begin
          next_len = cmd_word_i[svc_pkg::LENGTH_MSB:0];
          next_idx = 8'd0;
          next_crc_rx = svc_pkg::CRC_PRESET;
          next_crc_rd = svc_pkg::CRC_PRESET;
          next_ok = 1'b0;
          // RULE15 data length bound
          if (next_len > 8'(svc_pkg::LOAD_MAX_WORDS)) begin
            next_err = 1'b1;
            next_state = svc_pkg::ST_IDLE;
          end else begin
            next_state = (next_len == 8'd0) ? svc_pkg::ST_LD_SUM : svc_pkg::ST_LD_DATA;
          end
        end
      end
      svc_pkg::ST_LD_DATA: begin
        // RULE11 checksum and write
        // RULE16 crc over data only
        cmd_ready_o = cmd_valid_i;
        if (cmd_valid_i) begin
          next_crc_rx = crc_rx_step;
          next_we = 1'b1;
          next_wdata = cmd_word_i;
          next_addr = base + {8'h00, idx};
          next_idx = idx + 8'd1;
          if (idx + 8'd1 == len) begin
            next_state = svc_pkg::ST_LD_SUM;
          end
        end
      end
      svc_pkg::ST_LD_SUM: begin
        cmd_ready_o = cmd_valid_i;
        if (cmd_valid_i) begin
          next_sum = cmd_word_i;
          next_idx = 8'd0;
          next_state = svc_pkg::ST_LD_VERIFY;
        end
      end
      svc_pkg::ST_LD_VERIFY: begin
        // RULE11 re-read and recompute
        if (rd_pend) begin
          next_crc_rd = crc_rd_step;
        end
        if (idx != len) begin
          next_re = 1'b1;
          next_addr = base + {8'h00, idx};
          next_idx = idx + 8'd1;
        end else if (!rd_pend && !re) begin
          next_state = svc_pkg::ST_LD_REPORT;
        end
      end
      svc_pkg::ST_LD_REPORT: begin
        // RULE11 compare and report
        next_ok = (crc_rx == sum) && (crc_rd == sum);
        next_sum = crc_rd;
        next_err = !next_ok;
        next_done = 1'b1;
        next_state = svc_pkg::ST_IDLE;
      end
      default: begin
        next_state = svc_pkg::ST_IDLE;
      end
    endcase
  end

  // ------------------
  // registers
  // ------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= svc_pkg::ST_IDLE;
      hdr <= '{default: svc_pkg::WORD_RESET};
      hdr_cnt <= 3'd0;
      hdr_idx <= 3'd0;
      body_cnt <= 8'd0;
      len <= 8'd0;
      idx <= 8'd0;
      base <= svc_pkg::WORD_RESET;
      block <= svc_pkg::WORD_RESET;
      crc_rx <= svc_pkg::CRC_PRESET;
      crc_rd <= svc_pkg::CRC_PRESET;
      sum <= svc_pkg::WORD_RESET;
      ok <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      we <= 1'b0;
      re <= 1'b0;
      rd_pend <= 1'b0;
      wdata <= svc_pkg::WORD_RESET;
      addr <= svc_pkg::WORD_RESET;
    end else begin
      state <= next_state;
      hdr <= next_hdr;
      hdr_cnt <= next_hdr_cnt;
      hdr_idx <= next_hdr_idx;
      body_cnt <= next_body_cnt;
      len <= next_len;
      idx <= next_idx;
      base <= next_base;
      block <= next_block;
      crc_rx <= next_crc_rx;
      crc_rd <= next_crc_rd;
      sum <= next_sum;
      ok <= next_ok;
      done <= next_done;
      err <= next_err;
      we <= next_we;
      re <= next_re;
      rd_pend <= next_rd_pend;
      wdata <= next_wdata;
      addr <= next_addr;
    end
  end

  // outputs below straight from flip-flops, except busy_o, which is decoded from state; param_take_o and cmd_ready_o are combinational
  assign mem_we_o = we;
  assign mem_re_o = re;
  assign mem_block_o = block;
  assign mem_addr_o = addr;
  assign mem_wdata_o = wdata;
  assign busy_o = (state != svc_pkg::ST_IDLE);
  assign report_error_o = err;
  assign load_done_o = done;
  assign load_ok_o = ok;
  assign load_sum_o = sum;
endmodule

//--- include/svc_pkg.sv
/*
  shared constants for the service packet handler: subtypes, field widths,
  limits and state codes.
  assumes a single 100 MHz clock and a synchronous active-low reset.
*/
package svc_pkg;
  // report subtypes of the telemetry source data
  localparam logic [7:0] ST_HK_DEFS = 8'h0A;
  localparam logic [7:0] ST_DIAG_DEFS = 8'h0C;
  localparam logic [7:0] ST_HK_REPORT = 8'h19;
  localparam logic [7:0] ST_DIAG_REPORT = 8'h1A;
  localparam logic [7:0] ST_EVENT = 8'h01;
  localparam logic [7:0] ST_EXCEPTION = 8'h02;
  localparam logic [7:0] ST_ALARM = 8'h04;
  // event parameter limit in 16-bit words (42 octets)
  localparam int EVENT_PARAM_MAX_WORDS = 21;
  // load data limit in 16-bit words (230 octets)
  localparam int LOAD_MAX_WORDS = 115;
  // crc preset and polynomial of the load checksum
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // field positions within a word
  localparam int LENGTH_MSB = 7;
  // reset values
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_EMIT_HDR = 4'b0001,
    ST_EMIT_BODY = 4'b0010,
    ST_LD_MEMSEL = 4'b0011,
    ST_LD_ADDR = 4'b0100,
    ST_LD_LEN = 4'b0101,
    ST_LD_DATA = 4'b0110,
    ST_LD_SUM = 4'b0111,
    ST_LD_VERIFY = 4'b1000,
    ST_LD_REPORT = 4'b1001
  } state_type;
endpackage

//--- include/word_stream_if.sv
/*
  word stream carrier between the framer core and its output fifo.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface word_stream_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport source (output data, output valid, input ready);
  modport sink (input data, input valid, output ready);
endinterface

//--- design/word_fifo.sv
/*
  flip-flop fifo with valid and ready on both sides.
  assumes one clock; full and empty are exact.
*/
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  word_stream_if.sink in_s, // filling side
  output logic [WIDTH-1:0] out_data_o, // head word
  output logic out_valid_o, // head word present
  input wire logic out_ready_i // drain accepts head
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("word_fifo depth must be a power of two of at least two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;
  logic full;
  logic empty;

  // full when pointers differ only in wrap bit
  always_comb begin
    full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    empty = (wr_ptr == rd_ptr);
    push = in_s.valid && !full;
    pop = out_ready_i && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  assign in_s.ready = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  // pointers and storage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= in_s.data;
      end
    end
  end
endmodule

//--- design/crc16_step.sv
/*
  one 16-bit word step of the load checksum crc, msb first.
  assumes the caller holds the running value in its own register.
*/
`timescale 1ns/1ps
module crc16_step (
  input wire logic [15:0] crc_i, // running crc
  input wire logic [15:0] word_i, // data word
  output logic [15:0] crc_o // updated crc
);
  // bitwise shift over the sixteen data bits, most significant first
  always_comb begin
    logic [15:0] c;
    c = crc_i;
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ word_i[i]) begin
        c = {c[14:0], 1'b0} ^ svc_pkg::CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_o = c;
  end
endmodule

//--- verification/service_packet_handler_properties.sv
/* checker on the handler's top ports: refusals, first word, word hold,
   write stepping and read-back. assumes one clock, sync active-low reset. */
`timescale 1ns/1ps
module service_packet_handler_properties (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic report_req_i, // request
  input wire logic [7:0] report_subtype_i, // subtype
  input wire logic [15:0] report_def_id_i, // definition id
  input wire logic [15:0] structure_selector_i, // selector
  input wire logic [15:0] event_identifier_i, // event_identifier
  input wire logic [15:0] interval_i, // interval
  input wire logic [7:0] param_count_i, // count
  input wire logic param_take_o, // sampler pop
  input wire logic mem_we_o, // write
  input wire logic mem_re_o, // read
  input wire logic [15:0] mem_addr_o, // address
  input wire logic [15:0] tm_data_o, // word
  input wire logic tm_valid_o, // word present
  input wire logic tm_ready_i, // pop
  input wire logic busy_o, // busy
  input wire logic report_error_o, // refusal
  input wire logic load_done_o, // load end
  input wire logic load_ok_o // load verified
);
  // --------------------
  // request decode and helper state
  // --------------------
  logic take, is_def, is_per, is_evt, bad_iv, ok_req, first_due, next_first_due;
  logic [15:0] first_word, next_first_word;
  logic [3:0] since_rd, next_since_rd;
  assign take = report_req_i && !busy_o;
  assign is_def = report_subtype_i inside {svc_pkg::ST_HK_DEFS, svc_pkg::ST_DIAG_DEFS};
  assign is_per = report_subtype_i inside {svc_pkg::ST_HK_REPORT, svc_pkg::ST_DIAG_REPORT};
  assign is_evt = report_subtype_i inside {svc_pkg::ST_EVENT, svc_pkg::ST_EXCEPTION,
    svc_pkg::ST_ALARM};
  assign bad_iv = $countones(interval_i) != 1;
  assign ok_req = is_per || (is_def && !bad_iv)
    || (is_evt && param_count_i <= 8'(svc_pkg::EVENT_PARAM_MAX_WORDS));
  // armed on an empty fifo only, so no stale word counts
  always_comb begin
    next_first_due = first_due;
    next_first_word = first_word;
    next_since_rd = (since_rd == 4'hF) ? since_rd : since_rd + 4'h1;
    if (mem_re_o) begin
      next_since_rd = 4'h0;
    end
    if (tm_valid_o && tm_ready_i) begin
      next_first_due = 1'b0;
    end
    if (take && ok_req && !tm_valid_o) begin
      next_first_due = 1'b1;
      next_first_word = is_def ? report_def_id_i : (is_per ? structure_selector_i :
        event_identifier_i);
    end
  end
  // registers only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      first_due <= 1'b0;
      first_word <= 16'h0000;
      since_rd <= 4'hF;
    end else begin
      first_due <= next_first_due;
      first_word <= next_first_word;
      since_rd <= next_since_rd;
    end
  end
  // --------------------
  // properties
  // --------------------
  default clocking main_cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence refused_req;
    take && !ok_req;
  endsequence
  sequence accepted_req;
    take && ok_req;
  endsequence
  AST_REFUSED: assert property (refused_req |=> report_error_o && !busy_o)
    else $error("refused request not flagged");
  AST_INTERVAL: assert property (take && is_def && bad_iv |=> !busy_o [*2])
    else $error("odd interval accepted");
  AST_ACCEPTED: assert property (accepted_req |=> busy_o && !report_error_o)
    else $error("good request not started");
  AST_FIRST_WORD: assert property (first_due && tm_valid_o |-> tm_data_o == first_word)
    else $error("first report word wrong");
  AST_WORD_HOLD: assert property (tm_valid_o && !tm_ready_i |=> tm_valid_o && $stable(tm_data_o))
    else $error("output word changed before pop");
  AST_TAKE_BUSY: assert property (param_take_o |-> busy_o)
    else $error("sampler taken while idle");
  AST_WRITE_STEP: assert property (mem_we_o ##1 mem_we_o |-> mem_addr_o == $past(mem_addr_o) + 16'h0001)
    else $error("write address did not step by one");
  AST_REREAD: assert property (load_done_o && load_ok_o |-> since_rd < 4'h8)
    else $error("load ended without read-back");
  AST_FAIL_FLAG: assert property (load_done_o |-> report_error_o == !load_ok_o)
    else $error("load result and error disagree");
endmodule
bind service_packet_handler service_packet_handler_properties properties_inst (.clk_i,
  .rst_n_i, .report_req_i,
  .report_subtype_i, .report_def_id_i, .structure_selector_i, .event_identifier_i,
  .interval_i, .param_count_i, .param_take_o, .mem_we_o, .mem_re_o, .mem_addr_o,
  .tm_data_o, .tm_valid_o, .tm_ready_i, .busy_o, .report_error_o, .load_done_o, .load_ok_o);

//--- verification/ground_link_model.sv
/* downlink side model: pops telemetry words with a stall pattern and
   keeps every word taken in order. assumes one clock. */
`timescale 1ns/1ps
module ground_link_model (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic hold_i, // bench stall
  input wire logic [15:0] tm_data_i, // word
  input wire logic tm_valid_i, // word present
  output logic tm_ready_o = 1'b0 // pop
);
  logic [15:0] got [$]; // words in arrival order
  logic [2:0] phase; // one stall in eight
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase <= 3'h0;
      tm_ready_o <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      tm_ready_o <= !hold_i && phase != 3'h5;
      if (tm_valid_i && tm_ready_o) begin
        got.push_back(tm_data_i);
      end
    end
  end
endmodule

//--- verification/service_packet_handler_tb_top.sv
/* bench: reports of every subtype, refusals, stalled downlink, loads.
   assumes the ground link model and the bound checker. */
`timescale 1ns/1ps
module service_packet_handler_tb_top;
  logic clk_i = 1'b0, rst_n_i = 1'b0, report_req_i = 1'b0, cmd_valid_i = 1'b0;
  logic hold = 1'b0, flip = 1'b0;
  logic [7:0] report_subtype_i = 8'h00, param_count_i = 8'h00;
  logic [15:0] report_def_id_i = 16'h0000, structure_selector_i = 16'h0000;
  logic [15:0] event_identifier_i = 16'h0000, interval_i = 16'h0001, cmd_word_i = 16'h0000;
  logic [15:0] param_word_i = 16'h1000, mem_rdata_i = 16'h0000, blk = 16'h0000;
  logic tm_ready_i, param_take_o, cmd_ready_o, mem_we_o, mem_re_o, tm_valid_o, busy_o;
  logic report_error_o, load_done_o, load_ok_o;
  logic [15:0] mem_block_o, mem_addr_o, mem_wdata_o, tm_data_o, load_sum_o;
  logic [15:0] mem [0:255];
  logic [7:0] sts [7] = '{8'h0A, 8'h0C, 8'h19, 8'h1A, 8'h01, 8'h02, 8'h04};
  int seed = 54041;
  int err_count = 0;
  int samples_checked = 0;
  service_packet_handler #(.DEPTH(16), .MAX_PARAMS(255)) service_packet_handler_inst (.clk_i,
    .rst_n_i, .report_req_i, .report_subtype_i, .report_def_id_i, .structure_selector_i,
    .event_identifier_i, .interval_i, .param_count_i, .param_word_i, .param_take_o,
    .cmd_valid_i, .cmd_word_i, .cmd_ready_o, .mem_we_o, .mem_re_o, .mem_block_o, .mem_addr_o,
    .mem_wdata_o, .mem_rdata_i, .tm_data_o, .tm_valid_o, .tm_ready_i, .busy_o,
    .report_error_o, .load_done_o, .load_ok_o, .load_sum_o);
  ground_link_model ground_link_model_inst (.clk_i, .rst_n_i, .hold_i(hold),
    .tm_data_i(tm_data_o), .tm_valid_i(tm_valid_o), .tm_ready_o(tm_ready_i));
  initial forever #5 clk_i = ~clk_i;
  // memory and sampler stand-ins; idle read port shows inverse
  always @(posedge clk_i) begin
    if (mem_we_o) begin
      mem[mem_addr_o[7:0]] <= mem_wdata_o;
      chk_word(mem_block_o, blk);
    end
    mem_rdata_i <= mem_re_o ? mem[mem_addr_o[7:0]] ^ {15'h0000, flip} : ~mem_rdata_i;
    if (param_take_o) begin
      param_word_i <= param_word_i + 16'h0107;
    end
  end
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    chk_word({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic logic refused(input logic [7:0] st, input logic [15:0] iv,
    input logic [7:0] c);
    if (st inside {8'h0A, 8'h0C}) return $countones(iv) != 1;
    if (st inside {8'h01, 8'h02, 8'h04}) return c > 8'(svc_pkg::EVENT_PARAM_MAX_WORDS);
    return !(st inside {8'h19, 8'h1A});
  endfunction
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    c = c ^ w;
    for (int i = 0; i < 16; i++) c = c[15] ? {c[14:0], 1'b0} ^ svc_pkg::CRC_POLY : {c[14:0], 1'b0};
    return c;
  endfunction
  // command word held until taken; bounded
  task automatic cmd(input logic [15:0] w);
    int n;
    cmd_valid_i <= 1'b1;
    cmd_word_i <= w;
    n = 0;
    do begin @(posedge clk_i); n++; end while (!cmd_ready_o && n < 50);
    if (n >= 50) begin err_count++; give_verdict; end
  endtask
  task automatic report(input logic [7:0] st, input logic [15:0] iv, input logic [7:0] c,
    input int hd);
    logic [15:0] id, sel, ev, p;
    logic err;
    logic [15:0] exp [$];
    int n;
    id = 16'($random(seed));
    sel = 16'($random(seed));
    ev = 16'($random(seed));
    p = param_word_i;
    ground_link_model_inst.got.delete();
    hold <= hd != 0;
    {report_subtype_i, interval_i, param_count_i} <= {st, iv, c};
    {report_def_id_i, structure_selector_i, event_identifier_i} <= {id, sel, ev};
    report_req_i <= 1'b1;
    @(posedge clk_i);
    report_req_i <= 1'b0;
    @(posedge clk_i);
    err = report_error_o;
    if (hd != 0) begin
      repeat (hd) @(posedge clk_i);
      chk_flag(busy_o, 1'b1);
      hold <= 1'b0;
    end
    n = 0;
    do begin @(posedge clk_i); n++; end while ((busy_o || tm_valid_o) && n < 2000);
    if (n >= 2000) begin err_count++; give_verdict; end
    if (st inside {8'h0A, 8'h0C}) exp = '{id, sel, iv, {8'h00, c}};
    else if (st inside {8'h19, 8'h1A}) exp = '{sel};
    else exp = '{ev, sel};
    for (n = 0; n < c; n++) exp.push_back(p + 16'(n) * 16'h0107);
    if (refused(st, iv, c)) exp.delete();
    chk_flag(err, refused(st, iv, c));
    chk_word(16'(ground_link_model_inst.got.size()), 16'(exp.size()));
    foreach (exp[i]) chk_word(ground_link_model_inst.got[i], exp[i]);
  endtask
  task automatic load(input int len, input logic bad);
    logic [15:0] b, base, sum;
    logic [15:0] d [$];
    int n;
    b = 16'($random(seed));
    base = 16'($random(seed)) & 16'h007F;
    sum = svc_pkg::CRC_PRESET;
    blk <= b;
    flip <= bad;
    for (n = 0; n < len; n++) begin
      d.push_back(16'($random(seed)));
      sum = crc_step(sum, d[n]);
    end
    cmd(b);
    cmd(base);
    cmd({8'h00, 8'(len)});
    if (len <= svc_pkg::LOAD_MAX_WORDS) begin
      foreach (d[i]) cmd(d[i]);
      cmd(sum);
    end
    cmd_valid_i <= 1'b0;
    n = 0;
    while (!load_done_o && !report_error_o && n < 1000) begin @(posedge clk_i); n++; end
    if (n >= 1000) begin err_count++; give_verdict; end
    chk_flag(report_error_o, bad || len > svc_pkg::LOAD_MAX_WORDS);
    if (len <= svc_pkg::LOAD_MAX_WORDS) begin
      chk_flag(load_ok_o, !bad);
      if (!bad) chk_word(load_sum_o, sum);
      for (n = 0; n < len; n++) chk_word(mem[8'(base + 16'(n))], d[n]);
    end
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    chk_flag(busy_o | tm_valid_o | load_done_o | report_error_o, 1'b0);
    rst_n_i <= 1'b1;
    foreach (sts[i]) report(sts[i], 16'h0001 << i, 8'($random(seed)) & 8'h0F, 0);
    report(8'h0A, 16'h8000, 8'h00, 0);
    report(8'h0C, 16'h0003, 8'h02, 0);
    report(8'h04, 16'h0001, 8'h15, 0);
    report(8'h02, 16'h0001, 8'h16, 0);
    report(8'h03, 16'h0001, 8'h01, 0);
    report(8'h1A, 16'h0001, 8'h28, 80);
    repeat (8) report(sts[$unsigned($random(seed)) % 7], 16'h0002, 8'($random(seed)) & 8'h1F, 0);
    load(1, 1'b0);
    load(7, 1'b0);
    load(115, 1'b0);
    load(3, 1'b1);
    load(116, 1'b0);
    give_verdict;
  end
endmodule
